//--- src/usps_defs.svh
// Constants shared by both ends of the stepper phase sequencer link
`ifndef USPS_DEFS_SVH
`define USPS_DEFS_SVH

`define USPS_CLK_NS           100
`define USPS_STEP_PULSE_NS    10000
`define USPS_RESET_WAIT_NS    10000
`define USPS_DIR_HOLD_NS      6250
`define USPS_MODE_HOLD_NS     5000
// Least times round up to whole cycles
`define USPS_CYC(ns)          (((ns) + `USPS_CLK_NS - 1) / `USPS_CLK_NS)
`define USPS_STEP_PULSE_CYC   `USPS_CYC(`USPS_STEP_PULSE_NS)
`define USPS_RESET_WAIT_CYC   `USPS_CYC(`USPS_RESET_WAIT_NS)
`define USPS_DIR_HOLD_CYC     `USPS_CYC(`USPS_DIR_HOLD_NS)
`define USPS_MODE_HOLD_CYC    `USPS_CYC(`USPS_MODE_HOLD_NS)

// Winding bits {first_fwd, first_rev, second_fwd, second_rev}
`define USPS_W_FF             4'h8
`define USPS_W_FR             4'h4
`define USPS_W_SF             4'h2
`define USPS_W_SR             4'h1
`define USPS_W_OFF            4'h0
`define USPS_POS_INIT         3'h0

// Controller register byte offsets
`define USPS_REG_CTRL         8'h00
`define USPS_REG_STEPS        8'h04
`define USPS_REG_HALF         8'h08
`define USPS_REG_STATUS       8'h0C
// CTRL fields
`define USPS_CTRL_ENABLE      0
`define USPS_CTRL_EXCITE      1
`define USPS_CTRL_EDGE        2
`define USPS_CTRL_DIR         3
`define USPS_CTRL_SEQRST_N    4
`define USPS_CTRL_W           5
`define USPS_CTRL_RESET       5'h00
// STATUS fields
`define USPS_STAT_BUSY        0
`define USPS_STAT_FLAG_N      1
`define USPS_STAT_LEVEL_LSB   2

`endif

//--- src/usps_pkg.sv
// Types shared by both ends of the stepper phase sequencer link
`default_nettype none
package usps_pkg;
    // Three-level protection status, meaning encoded by kind of fault
    typedef enum logic [1:0] {
        USPS_FAULT_NONE,
        USPS_FAULT_OPEN,
        USPS_FAULT_OVERCURRENT,
        USPS_FAULT_OVERHEAT
    } usps_fault_type;

    typedef enum logic [1:0] {
        USPS_CTL_IDLE,
        USPS_CTL_SETTLE,
        USPS_CTL_RUN
    } usps_ctl_state_type;
endpackage
`default_nettype wire

//--- src/usps_link_if.sv
// Pin-level link between the step controller and the phase sequencer
`default_nettype none
interface usps_link_if;
    logic                   step_clk;
    logic                   excitation_select;
    logic                   edge_select;
    logic                   direction_select;
    logic                   sequence_reset_n;
    logic                   enable;
    logic                   protect_flag_o;
    logic                   protect_flag_oe_n;
    logic                   protect_flag_n;
    usps_pkg::usps_fault_type protect_level_out;

    // Open-drain flag with a pull-up
    assign protect_flag_n = protect_flag_oe_n ? 1'b1 : protect_flag_o;

    modport device (
        input  step_clk,
        input  excitation_select,
        input  edge_select,
        input  direction_select,
        input  sequence_reset_n,
        input  enable,
        output protect_flag_o,
        output protect_flag_oe_n,
        output protect_level_out
    );

    modport controller (
        output step_clk,
        output excitation_select,
        output edge_select,
        output direction_select,
        output sequence_reset_n,
        output enable,
        input  protect_flag_n,
        input  protect_level_out
    );
endinterface
`default_nettype wire

//--- src/usps_device.sv
// Phase sequencer and protection latch of the stepper driver
`include "usps_defs.svh"
`default_nettype none

// Behaviour
// - edge_select high: advance on rising step edges
// - edge_select low: advance on both step edges
// - excitation_select low two-phase, high half-step
// - direction_select low forward, high reverse
// - sequence_reset_n low holds sequencer in reset
// - reset release starts at first-fwd, second-rev
// - enable low forces all windings off
// - enable high resumes same sequence position
// - protect flag low after any detection
// - status output shows which protection fired
// - levels: open, overcurrent, overheat distinct
// - detections latch, cleared by reset or power-on
// - power-on reset until logic supply good
// - controller holds enable low during power-up
// - controller waits 10 us before first step
// - step clock at most 50 kHz, 10 us pulses
// - direction stable 6.25 us around rising edge
// - modes stable 5 us around rising edge
// - no step edge between mode and direction change
// - controller ramps step period down to stop; this controller keeps half_r fixed and does not ramp
module usps_device (
    // Clock and reset
    input  wire logic  clock_in,
    input  wire logic  reset_n_in,
    // Link to the controller
    usps_link_if.device link,
    // Supply monitor and fault detectors (asynchronous levels)
    input  wire logic  supply_good_in,
    input  wire logic  open_detect_in,
    input  wire logic  overcurrent_in,
    input  wire logic  overheat_in,
    // Winding drives
    output logic       first_winding_fwd_out,
    output logic       first_winding_rev_out,
    output logic       second_winding_fwd_out,
    output logic       second_winding_rev_out
);
    localparam int SYNC_W = 10;

    // Two-flop synchronisers for every asynchronous input
    logic [SYNC_W-1:0] sync1_r;
    logic [SYNC_W-1:0] sync2_r;
    wire  [SYNC_W-1:0] async_in = {
        link.step_clk, link.excitation_select, link.edge_select,
        link.direction_select, link.sequence_reset_n, link.enable,
        supply_good_in, open_detect_in, overcurrent_in, overheat_in
    };

    always_ff @(posedge clock_in) begin
        if (!reset_n_in) begin
            sync1_r <= '0;
            sync2_r <= '0;
        end else begin
            sync1_r <= async_in;
            sync2_r <= sync1_r;
        end
    end

    wire step_s      = sync2_r[9];
    wire excite_s    = sync2_r[8];
    wire edge_s      = sync2_r[7];
    wire dir_s       = sync2_r[6];
    wire seq_rst_n_s = sync2_r[5];
    wire enable_s    = sync2_r[4];
    wire supply_s    = sync2_r[3];
    wire open_s      = sync2_r[2];
    wire ovc_s       = sync2_r[1];
    wire heat_s      = sync2_r[0];

    logic step_prev_r;
    logic [2:0] pos_r;
    logic [2:0] pos_nxt;
    usps_pkg::usps_fault_type fault_r;
    usps_pkg::usps_fault_type fault_nxt;
    logic [3:0] wind_r;
    logic       flag_oe_n_r;
    usps_pkg::usps_fault_type level_r;

    // Power-on reset holds the sequencer in reset and the drive off until the supply is good
    wire por_active = !supply_s;
    wire seq_hold   = por_active || !seq_rst_n_s;

    wire rise_edge = step_s && !step_prev_r;
    wire fall_edge = !step_s && step_prev_r;
    // Rising only when edge_select is high, both edges otherwise
    wire step_evt  = rise_edge || (!edge_s && fall_edge);

    // Odd slot in two-phase mode moves one, so phase survives a mode swap
    wire [2:0] stride = (excite_s || pos_r[0]) ? 3'h1 : 3'h2;
    wire [2:0] pos_fwd = pos_r + stride;
    wire [2:0] pos_rev = pos_r - stride;

    always_comb begin
        pos_nxt = pos_r;
        if (step_evt) begin
            pos_nxt = dir_s ? pos_rev : pos_fwd;
        end
    end

    // First detection wins
    always_comb begin
        fault_nxt = fault_r;
        if (fault_r == usps_pkg::USPS_FAULT_NONE) begin
            if (open_s) begin
                fault_nxt = usps_pkg::USPS_FAULT_OPEN;
            end else if (ovc_s) begin
                fault_nxt = usps_pkg::USPS_FAULT_OVERCURRENT;
            end else if (heat_s) begin
                fault_nxt = usps_pkg::USPS_FAULT_OVERHEAT;
            end
        end
    end

    function automatic logic [3:0] phase_map(input logic [2:0] p);
        case (p)
            3'h0:    phase_map = `USPS_W_FF | `USPS_W_SR;
            3'h1:    phase_map = `USPS_W_FF;
            3'h2:    phase_map = `USPS_W_FF | `USPS_W_SF;
            3'h3:    phase_map = `USPS_W_SF;
            3'h4:    phase_map = `USPS_W_FR | `USPS_W_SF;
            3'h5:    phase_map = `USPS_W_FR;
            3'h6:    phase_map = `USPS_W_FR | `USPS_W_SR;
            3'h7:    phase_map = `USPS_W_SR;
            default: phase_map = `USPS_W_OFF;
        endcase
    endfunction

    wire fault_live = fault_r != usps_pkg::USPS_FAULT_NONE;
    // Position is kept while disabled, only the drive is gated
    wire drive_on   = enable_s && !fault_live && !seq_hold;
    wire [3:0] wind_nxt = drive_on ? phase_map(pos_r) : `USPS_W_OFF;

    always_ff @(posedge clock_in) begin
        if (!reset_n_in) begin
            step_prev_r <= 1'b0;
        end else begin
            step_prev_r <= step_s;
        end
    end

    always_ff @(posedge clock_in) begin
        if (!reset_n_in || seq_hold) begin
            pos_r <= `USPS_POS_INIT;
        end else begin
            pos_r <= pos_nxt;
        end
    end

    // Set wins over the clearing reset
    always_ff @(posedge clock_in) begin
        if (!reset_n_in) begin
            fault_r <= usps_pkg::USPS_FAULT_NONE;
        end else if (seq_hold && !(open_s || ovc_s || heat_s)) begin
            fault_r <= usps_pkg::USPS_FAULT_NONE;
        end else begin
            fault_r <= fault_nxt;
        end
    end

    always_ff @(posedge clock_in) begin
        if (!reset_n_in) begin
            wind_r      <= `USPS_W_OFF;
            flag_oe_n_r <= 1'b1;
            level_r     <= usps_pkg::USPS_FAULT_NONE;
        end else begin
            wind_r      <= wind_nxt;
            flag_oe_n_r <= !fault_live;
            level_r     <= fault_r;
        end
    end

    assign link.protect_flag_o    = 1'b0;
    assign link.protect_flag_oe_n = flag_oe_n_r;
    assign link.protect_level_out = level_r;

    assign first_winding_fwd_out  = wind_r[3];
    assign first_winding_rev_out  = wind_r[2];
    assign second_winding_fwd_out = wind_r[1];
    assign second_winding_rev_out = wind_r[0];
endmodule
`default_nettype wire

//--- src/usps_controller.sv
// Step/direction controller with an AHB-Lite register slave
//
// Register access over AHB-Lite and the register addresses were chosen for this implementation.
`include "usps_defs.svh"
`default_nettype none
module usps_controller #(
    parameter int COUNT_W = 16
) (
    // Clock and reset
    input  wire logic        clock_in,
    input  wire logic        reset_n_in,
    // AHB-Lite slave
    input  wire logic        hsel_in,
    input  wire logic [7:0]  haddr_in,
    input  wire logic [1:0]  htrans_in,
    input  wire logic        hwrite_in,
    input  wire logic [2:0]  hsize_in,
    input  wire logic [31:0] hwdata_in,
    input  wire logic        hready_in,
    output logic [31:0]      hrdata_out,
    output logic             hreadyout_out,
    output logic             hresp_out,
    // Link to the sequencer
    usps_link_if.controller  link
);
    generate
        if (COUNT_W < 8 || COUNT_W > 32) begin : g_bad_w
            $error("usps_controller: COUNT_W must be 8..32");
        end
    endgenerate

    localparam logic [COUNT_W-1:0] HALF_MIN = COUNT_W'(`USPS_STEP_PULSE_CYC);
    localparam logic [COUNT_W-1:0] HOLD_CYC = COUNT_W'(`USPS_DIR_HOLD_CYC);
    localparam logic [COUNT_W-1:0] WAIT_CYC = COUNT_W'(`USPS_RESET_WAIT_CYC);

    logic [`USPS_CTRL_W-1:0] ctrl_r;
    logic [`USPS_CTRL_W-1:0] pins_r;
    logic [COUNT_W-1:0]      steps_r;
    logic [COUNT_W-1:0]      half_r;
    logic [COUNT_W-1:0]      tmr_r;
    logic                    clk_r;
    logic [7:0]              addr_r;
    logic                    wr_r;
    logic [31:0]             rdata_r;
    logic [2:0]              fsync1_r;
    logic [2:0]              fsync2_r;
    usps_pkg::usps_ctl_state_type state_r;

    // Address phase taken when selected, NONSEQ/SEQ and ready
    wire take    = hsel_in && htrans_in[1] && hready_in;
    wire wr_ctrl = wr_r && addr_r == `USPS_REG_CTRL;
    wire wr_step = wr_r && addr_r == `USPS_REG_STEPS;
    wire wr_half = wr_r && addr_r == `USPS_REG_HALF;
    wire busy    = state_r != usps_pkg::USPS_CTL_IDLE || steps_r != '0;
    wire [31:0] status = {28'h000_0000, fsync2_r[1:0], fsync2_r[2],
        busy};
    wire [31:0] rd_mux =
        (haddr_in == `USPS_REG_CTRL)   ? {27'h000_0000, ctrl_r} :
        (haddr_in == `USPS_REG_STEPS)  ? 32'(steps_r) :
        (haddr_in == `USPS_REG_HALF)   ? 32'(half_r) :
        (haddr_in == `USPS_REG_STATUS) ? status : 32'h0000_0000;
    // Too short a half period is stretched to the least pulse width
    wire [COUNT_W-1:0] half_use = (half_r < HALF_MIN) ? HALF_MIN
        : half_r;
    // Rising-only mode counts a step per rising edge
    wire counts = !pins_r[`USPS_CTRL_EDGE] || !clk_r;
    wire pins_differ = pins_r != ctrl_r;
    wire rst_release = !pins_r[`USPS_CTRL_SEQRST_N] &&
        ctrl_r[`USPS_CTRL_SEQRST_N];

    always_ff @(posedge clock_in) begin
        if (!reset_n_in) begin
            addr_r  <= 8'h00;
            wr_r    <= 1'b0;
            rdata_r <= 32'h0000_0000;
        end else begin
            addr_r  <= haddr_in;
            wr_r    <= take && hwrite_in;
            rdata_r <= (take && !hwrite_in) ? rd_mux : rdata_r;
        end
    end

    always_ff @(posedge clock_in) begin
        if (!reset_n_in) begin
            fsync1_r <= 3'h0;
            fsync2_r <= 3'h0;
        end else begin
            fsync1_r <= {link.protect_flag_n, link.protect_level_out};
            fsync2_r <= fsync1_r;
        end
    end

    always_ff @(posedge clock_in) begin
        if (!reset_n_in) begin
            ctrl_r <= `USPS_CTRL_RESET;
            half_r <= HALF_MIN;
        end else begin
            ctrl_r <= wr_ctrl ? hwdata_in[`USPS_CTRL_W-1:0] : ctrl_r;
            half_r <= wr_half ? hwdata_in[COUNT_W-1:0] : half_r;
        end
    end

    // Pins change only when idle and held off, all in one cycle so
    // no step edge falls between mode and direction change.
    always_ff @(posedge clock_in) begin
        if (!reset_n_in) begin
            state_r <= usps_pkg::USPS_CTL_IDLE;
            pins_r  <= `USPS_CTRL_RESET;
            steps_r <= '0;
            tmr_r   <= '0;
            clk_r   <= 1'b0;
        end else begin
            steps_r <= wr_step ? hwdata_in[COUNT_W-1:0] : steps_r;
            case (state_r)
                usps_pkg::USPS_CTL_IDLE: begin
                    if (tmr_r != '0) begin
                        tmr_r <= tmr_r - 1'b1;
                    end else if (pins_differ) begin
                        pins_r  <= ctrl_r;
                        tmr_r   <= rst_release ? WAIT_CYC : HOLD_CYC;
                        state_r <= usps_pkg::USPS_CTL_SETTLE;
                    end else if (steps_r != '0 && !wr_step &&
                                 pins_r[`USPS_CTRL_SEQRST_N]) begin
                        tmr_r   <= half_use;
                        state_r <= usps_pkg::USPS_CTL_RUN;
                    end
                end
                usps_pkg::USPS_CTL_SETTLE: begin
                    if (tmr_r != '0) begin
                        tmr_r <= tmr_r - 1'b1;
                    end else begin
                        state_r <= usps_pkg::USPS_CTL_IDLE;
                    end
                end
                usps_pkg::USPS_CTL_RUN: begin
                    if (tmr_r != '0) begin
                        tmr_r <= tmr_r - 1'b1;
                    end else begin
                        clk_r <= !clk_r;
                        tmr_r <= half_use;
                        if (counts) begin
                            steps_r <= steps_r - 1'b1;
                        end
                        if (clk_r && (steps_r == '0 ||
                            (counts && steps_r == 1))) begin
                            state_r <= usps_pkg::USPS_CTL_IDLE;
                            tmr_r   <= HOLD_CYC;
                        end else if (!clk_r && steps_r == 1 &&
                                     !pins_r[`USPS_CTRL_EDGE]) begin
                            state_r <= usps_pkg::USPS_CTL_IDLE;
                            tmr_r   <= HOLD_CYC;
                        end
                    end
                end
                default: state_r <= usps_pkg::USPS_CTL_IDLE;
            endcase
        end
    end

    assign hrdata_out    = rdata_r;
    assign hreadyout_out = 1'b1;
    assign hresp_out     = 1'b0;

    assign link.step_clk          = clk_r;
    assign link.enable            = pins_r[`USPS_CTRL_ENABLE];
    assign link.excitation_select = pins_r[`USPS_CTRL_EXCITE];
    assign link.edge_select       = pins_r[`USPS_CTRL_EDGE];
    assign link.direction_select  = pins_r[`USPS_CTRL_DIR];
    assign link.sequence_reset_n  = pins_r[`USPS_CTRL_SEQRST_N];
endmodule
`default_nettype wire

//--- verif/usps_link_monitor.sv
// Checker on the controller to sequencer link and the winding drives
`include "usps_defs.svh"
`default_nettype none
module usps_link_monitor (
    // Clock and reset
    input wire logic                     clock_in,
    input wire logic                     reset_n_in,
    // Link and device pins
    input wire logic                     step_clk,
    input wire logic                     edge_select,
    input wire logic                     sequence_reset_n,
    input wire logic                     enable,
    input wire logic                     protect_flag_n,
    input wire usps_pkg::usps_fault_type protect_level_out,
    input wire logic                     supply_good_in,
    input wire logic                     first_winding_fwd_out,
    input wire logic                     first_winding_rev_out,
    input wire logic                     second_winding_fwd_out,
    input wire logic                     second_winding_rev_out
);
    wire logic [3:0] wind = {first_winding_fwd_out, first_winding_rev_out,
                             second_winding_fwd_out, second_winding_rev_out};
    wire logic       edge_ev;
    logic            step_q;
    logic            srst_q;
    logic [15:0]     gap_r;

    assign edge_ev = step_q != step_clk || (sequence_reset_n && !srst_q);
    // Gap since the last step edge or sequence reset release
    always_ff @(posedge clock_in) begin
        step_q <= step_clk;
        srst_q <= sequence_reset_n;
        if (!reset_n_in || edge_ev) begin
            gap_r <= 16'h0000;
        end else if (gap_r != 16'hFFFF) begin
            gap_r <= gap_r + 16'h0001;
        end
    end

    default clocking cb @(posedge clock_in);
    endclocking
    default disable iff (!reset_n_in);

    property p_enable_off; !enable [*4] |-> wind == 4'h0; endproperty
    a_enable_off: assert property (p_enable_off)
        else $error("windings on while enable low");
    property p_seqrst_off;
        !sequence_reset_n [*4] |-> wind == 4'h0;
    endproperty
    a_seqrst_off: assert property (p_seqrst_off)
        else $error("windings on while sequence reset held");
    property p_fault_off; !protect_flag_n [*3] |-> wind == 4'h0; endproperty
    a_fault_off: assert property (p_fault_off)
        else $error("windings on after protection fired");
    property p_flag_level;
        protect_flag_n == (protect_level_out == usps_pkg::USPS_FAULT_NONE);
    endproperty
    a_flag_level: assert property (p_flag_level)
        else $error("flag and status level disagree");
    property p_level_latch;
        (sequence_reset_n && supply_good_in) [*4] ##0
            protect_level_out != usps_pkg::USPS_FAULT_NONE
            |=> $stable(protect_level_out);
    endproperty
    a_level_latch: assert property (p_level_latch)
        else $error("latched fault changed without reset");
    property p_step_advance;
        ($rose(step_clk) || (!edge_select && $fell(step_clk))) && enable
            && protect_flag_n |-> ##[1:6] $changed(wind);
    endproperty
    a_step_advance: assert property (p_step_advance)
        else $error("step edge did not move the windings");
    property p_rise_only;
        edge_select && $fell(step_clk) |=> $stable(wind) [*6];
    endproperty
    a_rise_only: assert property (p_rise_only)
        else $error("falling edge moved windings in rising mode");
    property p_seq_init;
        $rose(sequence_reset_n) ##1 enable [*6] |-> wind == 4'h9;
    endproperty
    a_seq_init: assert property (p_seq_init)
        else $error("sequence reset release not at initial state");
    property p_step_gap;
        step_q != step_clk |-> gap_r >= `USPS_STEP_PULSE_CYC - 1;
    endproperty
    a_step_gap: assert property (p_step_gap)
        else $error("step edge too soon");

    c_both: cover property (!edge_select && $fell(step_clk));
    c_fault: cover property ($fell(protect_flag_n));
    c_off: cover property ($fell(enable));
endmodule
`default_nettype wire

//--- verif/unipolar_stepper_phase_sequencer_tb.sv
// Bench for the step controller and sequencer joined by their link
`include "usps_defs.svh"
`default_nettype none
module unipolar_stepper_phase_sequencer_tb;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int LIM = 2000;
    logic             clock_in = 1'b0;
    logic             reset_n_in = 1'b0;
    logic             supply_good_in = 1'b1;
    logic [2:0]       det = 3'h0;
    logic             hsel = 1'b0;
    logic [7:0]       haddr = 8'h00;
    logic [1:0]       htrans = 2'h0;
    logic             hwrite = 1'b0;
    logic [31:0]      hwdata = 32'h0000_0000;
    logic [31:0]      rd;
    logic [4:0]       c;
    logic             step_q = 1'b0;
    wire logic        hready;
    wire logic [31:0] hrdata;
    wire logic [3:0]  wind;
    int               error_cnt = 0;
    int               n_compared = 0;
    int               rises = 0;
    int               edges = 0;
    int               pos = 0;
    int               n, n0;
    logic [3:0]       wtab [8] = '{4'h9, 4'h8, 4'hA, 4'h2,
                                   4'h6, 4'h4, 4'h5, 4'h1};
    usps_pkg::usps_fault_type lv [3] = '{usps_pkg::USPS_FAULT_OPEN,
        usps_pkg::USPS_FAULT_OVERCURRENT, usps_pkg::USPS_FAULT_OVERHEAT};

    usps_link_if link ();
    usps_controller u_usps_controller (
        .clock_in(clock_in), .reset_n_in(reset_n_in), .hsel_in(hsel),
        .haddr_in(haddr), .htrans_in(htrans), .hwrite_in(hwrite),
        .hsize_in(3'h2), .hwdata_in(hwdata), .hready_in(hready),
        .hrdata_out(hrdata), .hreadyout_out(hready), .hresp_out(),
        .link(link.controller));
    usps_device u_usps_device (
        .clock_in(clock_in), .reset_n_in(reset_n_in), .link(link.device),
        .supply_good_in(supply_good_in), .open_detect_in(det[0]),
        .overcurrent_in(det[1]), .overheat_in(det[2]),
        .first_winding_fwd_out(wind[3]), .first_winding_rev_out(wind[2]),
        .second_winding_fwd_out(wind[1]), .second_winding_rev_out(wind[0]));
    usps_link_monitor u_usps_link_monitor (
        .clock_in(clock_in), .reset_n_in(reset_n_in),
        .step_clk(link.step_clk), .edge_select(link.edge_select),
        .sequence_reset_n(link.sequence_reset_n), .enable(link.enable),
        .protect_flag_n(link.protect_flag_n),
        .protect_level_out(link.protect_level_out),
        .supply_good_in(supply_good_in),
        .first_winding_fwd_out(wind[3]), .first_winding_rev_out(wind[2]),
        .second_winding_fwd_out(wind[1]), .second_winding_rev_out(wind[0]));

    always #50 clock_in = ~clock_in;

    // Step clock edges seen on the wire
    always @(posedge clock_in) begin
        step_q <= link.step_clk;
        if (step_q !== link.step_clk) begin
            edges <= edges + 1;
            rises <= rises + (link.step_clk === 1'b1);
        end
    end

    task automatic end_sim();
        $display("compared %0d, mismatches %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    task automatic chk(input string what, input logic [31:0] exp,
                       input logic [31:0] got);
        n_compared++;
        if (got !== exp) begin
            error_cnt++;
            $display("unexpected %s: expected %h, seen %h", what, exp, got);
        end
    endtask

    task automatic bound(input int k);
        if (k >= LIM) begin
            error_cnt++;
            $display("unexpected wait: expected an answer, seen none");
            end_sim();
        end
    endtask

    task automatic wait_cyc(input int k);
        repeat (k) @(posedge clock_in);
    endtask

    task automatic wait_rdy();
        int k;
        k = 0;
        do begin
            @(posedge clock_in);
            k++;
        end while (hready !== 1'b1 && k < LIM);
        bound(k);
    endtask

    // One single AHB-Lite word transfer; the data phase follows the address
    task automatic ahb(input logic [7:0] a, input logic w,
                       input logic [31:0] wd, output logic [31:0] q);
        hsel <= 1'b1;
        haddr <= a;
        htrans <= 2'h2;
        hwrite <= w;
        wait_rdy();
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        wait_rdy();
        q = hrdata;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        ahb(a, 1'b1, d, rd);
    endtask

    task automatic rdchk(input string what, input logic [7:0] a,
                         input logic [31:0] exp);
        ahb(a, 1'b0, 32'h0000_0000, rd);
        chk(what, exp, rd);
    endtask

    // Pins follow only once the controller is idle, then settle
    task automatic set_ctrl(input logic [4:0] v);
        wr(`USPS_REG_CTRL, {27'h000_0000, v});
        wait_cyc(200);
    endtask

    task automatic run(input int k);
        int t;
        wr(`USPS_REG_STEPS, k);
        t = 0;
        do begin
            wait_cyc(20);
            ahb(`USPS_REG_STATUS, 1'b0, 32'h0000_0000, rd);
            t++;
        end while (rd[`USPS_STAT_BUSY] !== 1'b0 && t < LIM);
        bound(t);
        rdchk("steps left", `USPS_REG_STEPS, 32'h0000_0000);
        wait_cyc(10);
    endtask

    // Two-phase from an odd slot moves one slot only
    function automatic int nxt(input int p, input logic half,
                               input logic rev);
        int d;
        d = (half || p[0]) ? 1 : 2;
        return rev ? (p + 8 - d) % 8 : (p + d) % 8;
    endfunction

    initial begin
        wait_cyc(3);
        reset_n_in <= 1'b1;
        wait_cyc(3);
        chk("windings", 4'h0, wind);
        chk("flag", 1'h1, link.protect_flag_n);
        rdchk("ctrl", `USPS_REG_CTRL, 32'h0000_0000);
        rdchk("half", `USPS_REG_HALF, 32'h0000_0064);
        rdchk("status", `USPS_REG_STATUS, 32'h0000_0002);
        wr(8'h10, 32'h0000_001F);
        rdchk("unmapped", 8'h10, 32'h0000_0000);
        rdchk("ctrl", `USPS_REG_CTRL, 32'h0000_0000);
        wr(`USPS_REG_HALF, 32'h0000_0078);
        rdchk("half", `USPS_REG_HALF, 32'h0000_0078);
        $display("test registers done");
        set_ctrl(5'h13);
        chk("windings", 4'h9, wind);
        for (int i = 0; i < 8; i++) begin
            c = {1'b1, i[2:0], 1'b1};
            set_ctrl(c);
            n = c[2] ? 5 : 6;
            n0 = c[2] ? rises : edges;
            run(n);
            for (int s = 0; s < n; s++) begin
                pos = nxt(pos, c[1], c[3]);
            end
            chk("windings", wtab[pos], wind);
            chk("edges", n, (c[2] ? rises : edges) - n0);
            chk("step idle", 1'h0, link.step_clk);
        end
        $display("test stepping done");
        c[0] = 1'b0;
        set_ctrl(c);
        chk("windings", 4'h0, wind);
        c[0] = 1'b1;
        set_ctrl(c);
        chk("windings", wtab[pos], wind);
        $display("test enable done");
        for (int f = 0; f < 3; f++) begin
            det[f] <= 1'b1;
            wait_cyc(5);
            det <= 3'h0;
            wait_cyc(10);
            chk("flag", 1'h0, link.protect_flag_n);
            chk("level", lv[f], link.protect_level_out);
            chk("windings", 4'h0, wind);
            rdchk("status", `USPS_REG_STATUS, {lv[f], 2'h0});
            set_ctrl(5'h03);
            set_ctrl(5'h13);
            chk("flag", 1'h1, link.protect_flag_n);
            chk("windings", 4'h9, wind);
        end
        $display("test faults done");
        det[1] <= 1'b1;
        wait_cyc(5);
        det <= 3'h0;
        supply_good_in <= 1'b0;
        wait_cyc(5);
        supply_good_in <= 1'b1;
        wait_cyc(10);
        chk("flag", 1'h1, link.protect_flag_n);
        chk("level", 2'h0, link.protect_level_out);
        chk("windings", 4'h9, wind);
        $display("test power-on reset done");
        reset_n_in <= 1'b0;
        wait_cyc(3);
        reset_n_in <= 1'b1;
        wait_cyc(3);
        chk("windings", 4'h0, wind);
        rdchk("ctrl", `USPS_REG_CTRL, 32'h0000_0000);
        $display("test second reset done");
        end_sim();
    end
endmodule
`default_nettype wire
